// [hdl/amsc_ctrl.v]
// Notes on behaviour
// R1 - Read: selects, byte enables, address, output enable valid setup periods before strobe.
// R2 - After read strobe rises, all selects held for read-hold periods.
// R3 - Write: selects and write data valid write-setup periods before write strobe.
// R4 - After write strobe rises, selects and data held for write-hold periods.
// R5 - Select group: space selects, byte enables, word address, output enable, write data.
// R6 - All six phase counts come from per-space configuration inputs.
// R7 - Read data captured when read strobe rises, starting read hold.
// R8 - Ready passes an internal synchroniser before the sequencer uses it.
// R9 - Ready sampled on memory clock rising edges, acted on at that edge.
// R10 - Memory side keeps each ready level about two memory clock periods.
// R11 - Shared control pins act as output enable, read and write strobes.
// R12 - Strobes change only at memory clock output rising edges.
// R13 - Memory clock output follows memory clock input edge for edge.
// R14 - Strobe lasts programmed count, extended whole periods while ready is low.
`timescale 1ns/1ps
`default_nettype none
`include "amsc_regs.vh"

module amsc_ctrl (
  // Clock and reset
  input  wire                                      core_clk,
  input  wire                                      rstn,
  // Memory clock
  input  wire                                      mem_clock_in,
  output reg                                       mem_clock_out,
  // Per-space read timing
  input  wire [`AMSC_SPACES*`AMSC_SETUP_W-1:0]     cfg_read_setup_cycles,
  input  wire [`AMSC_SPACES*`AMSC_STROBE_W-1:0]    cfg_read_strobe_cycles,
  input  wire [`AMSC_SPACES*`AMSC_HOLD_W-1:0]      cfg_read_hold_cycles,
  // Per-space write timing
  input  wire [`AMSC_SPACES*`AMSC_SETUP_W-1:0]     cfg_write_setup_cycles,
  input  wire [`AMSC_SPACES*`AMSC_STROBE_W-1:0]    cfg_write_strobe_cycles,
  input  wire [`AMSC_SPACES*`AMSC_HOLD_W-1:0]      cfg_write_hold_cycles,
  // Access request
  input  wire                                      req_valid,
  input  wire                                      req_write,
  input  wire [`AMSC_SPACE_W-1:0]                  req_space,
  input  wire [`AMSC_ADDR_W-1:0]                   req_addr,
  input  wire [`AMSC_BE_W-1:0]                     req_byte_en,
  input  wire [`AMSC_DATA_W-1:0]                   req_wdata,
  output reg                                       req_ready,
  // Access answer
  output reg                                       rsp_valid,
  output reg  [`AMSC_DATA_W-1:0]                   rsp_rdata,
  output reg                                       busy,
  // Memory select group
  output reg  [`AMSC_SPACES-1:0]                   chip_space_select_n,
  output reg  [`AMSC_BE_W-1:0]                     byte_lane_enable_n,
  output reg  [`AMSC_ADDR_W-1:0]                   word_address,
  output reg                                       output_enable_n,
  // Memory strobes
  output reg                                       read_strobe_n,
  output reg                                       write_strobe_n,
  input  wire                                      async_ready,
  // Memory data bus, split in three
  input  wire [`AMSC_DATA_W-1:0]                   mem_data_in,
  output reg  [`AMSC_DATA_W-1:0]                   mem_data_out,
  output reg                                       mem_data_oe_n
);

  // ****************************************
  // States
  // ****************************************
  localparam [1:0] ST_IDLE   = 2'b00;
  localparam [1:0] ST_SETUP  = 2'b01;
  localparam [1:0] ST_STROBE = 2'b10;
  localparam [1:0] ST_HOLD   = 2'b11;

  // ****************************************
  // Decoding helpers
  // ****************************************
  // Active-low one-hot select for a space index
  function [`AMSC_SPACES-1:0] space_sel_n;
    input [`AMSC_SPACE_W-1:0] idx;
    begin
      space_sel_n = ~({{(`AMSC_SPACES-1){1'b0}}, 1'b1} << idx);
    end
  endfunction

  // A programmed zero still gives one whole period
  function [`AMSC_CNT_W-1:0] at_least_one;
    input [`AMSC_CNT_W-1:0] v;
    begin
      if (v == `AMSC_CNT_RST) begin
        at_least_one = `AMSC_CNT_ONE;
      end else begin
        at_least_one = v;
      end
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [`AMSC_DATA_W+1:0] sync_out;
  wire                    clk_s;
  wire                    ready_s;
  wire [`AMSC_DATA_W-1:0] data_s;

  // R8 ready synchroniser
  amsc_sync #(
    .WIDTH (`AMSC_DATA_W + 2)
  ) u_sync (
    .core_clk (core_clk),
    .rstn     (rstn),
    .async_in ({mem_clock_in, async_ready, mem_data_in}),
    .sync_out (sync_out)
  );

  assign clk_s   = sync_out[`AMSC_DATA_W+1];
  assign ready_s = sync_out[`AMSC_DATA_W];
  assign data_s  = sync_out[`AMSC_DATA_W-1:0];

  // ****************************************
  // Memory clock follower
  // ****************************************
  // R13 clock follows input
  always @(posedge core_clk) begin
    if (!rstn) begin
      mem_clock_out <= 1'b0;
    end else begin
      mem_clock_out <= clk_s;
    end
  end

  // R12 strobe edge enable
  // Same core edge that raises the output clock moves the strobes
  wire ek_rise = clk_s & ~mem_clock_out;

  // ****************************************
  // Request capture
  // ****************************************
  reg                     pend_q;
  reg                     write_q;
  reg [`AMSC_SPACE_W-1:0] space_q;
  reg [`AMSC_ADDR_W-1:0]  addr_q;
  reg [`AMSC_BE_W-1:0]    be_q;
  reg [`AMSC_DATA_W-1:0]  wdata_q;
  reg [1:0]               state_q;
  reg [1:0]               state_d;

  wire take_req = req_valid & req_ready;

  always @(posedge core_clk) begin
    if (!rstn) begin
      write_q <= 1'b0;
      space_q <= {`AMSC_SPACE_W{1'b0}};
      addr_q  <= `AMSC_ADDR_RST;
      be_q    <= {`AMSC_BE_W{1'b0}};
      wdata_q <= `AMSC_DATA_RST;
    end else if (take_req) begin
      write_q <= req_write;
      space_q <= req_space;
      addr_q  <= req_addr;
      be_q    <= req_byte_en;
      wdata_q <= req_wdata;
    end
  end

  // ****************************************
  // Phase lengths
  // ****************************************
  // R6 per-space counts
  wire [`AMSC_SETUP_W-1:0]  rd_setup  = cfg_read_setup_cycles[space_q*`AMSC_SETUP_W +: `AMSC_SETUP_W];
  wire [`AMSC_STROBE_W-1:0] rd_strobe = cfg_read_strobe_cycles[space_q*`AMSC_STROBE_W +: `AMSC_STROBE_W];
  wire [`AMSC_HOLD_W-1:0]   rd_hold   = cfg_read_hold_cycles[space_q*`AMSC_HOLD_W +: `AMSC_HOLD_W];
  wire [`AMSC_SETUP_W-1:0]  wr_setup  = cfg_write_setup_cycles[space_q*`AMSC_SETUP_W +: `AMSC_SETUP_W];
  wire [`AMSC_STROBE_W-1:0] wr_strobe = cfg_write_strobe_cycles[space_q*`AMSC_STROBE_W +: `AMSC_STROBE_W];
  wire [`AMSC_HOLD_W-1:0]   wr_hold   = cfg_write_hold_cycles[space_q*`AMSC_HOLD_W +: `AMSC_HOLD_W];

  wire [`AMSC_CNT_W-1:0] setup_len;
  wire [`AMSC_CNT_W-1:0] strobe_len;
  wire [`AMSC_CNT_W-1:0] hold_len;

  assign setup_len  = at_least_one(write_q ? {2'b00, wr_setup} : {2'b00, rd_setup});
  assign strobe_len = at_least_one(write_q ? wr_strobe : rd_strobe);
  assign hold_len   = at_least_one(write_q ? {3'b000, wr_hold} : {3'b000, rd_hold});

  // ****************************************
  // Phase counter
  // ****************************************
  reg                   cnt_load;
  reg [`AMSC_CNT_W-1:0] cnt_val;
  wire                  cnt_last;

  amsc_phase_cnt u_cnt (
    .core_clk (core_clk),
    .rstn     (rstn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .step     (ek_rise),
    .last     (cnt_last)
  );

  // ****************************************
  // Sequencer
  // ****************************************
  always @* begin
    state_d  = state_q;
    cnt_load = 1'b0;
    cnt_val  = setup_len;
    if (ek_rise) begin
      case (state_q)
        ST_IDLE: begin
          if (pend_q) begin
            state_d  = ST_SETUP;
            cnt_load = 1'b1;
            cnt_val  = setup_len;
          end
        end
        ST_SETUP: begin
          if (cnt_last) begin
            state_d  = ST_STROBE;
            cnt_load = 1'b1;
            cnt_val  = strobe_len;
          end
        end
        ST_STROBE: begin
          // R14 ready stretches strobe
          // R9 ready acted on at edge
          if (cnt_last && ready_s) begin
            state_d  = ST_HOLD;
            cnt_load = 1'b1;
            cnt_val  = hold_len;
          end
        end
        ST_HOLD: begin
          if (cnt_last) begin
            state_d = ST_IDLE;
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Handshake and status
  // ****************************************
  wire access_start = (state_q == ST_IDLE) && (state_d == ST_SETUP);
  wire access_end   = (state_q == ST_HOLD) && (state_d == ST_IDLE);

  always @(posedge core_clk) begin
    if (!rstn) begin
      pend_q    <= 1'b0;
      req_ready <= 1'b1;
      busy      <= 1'b0;
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= access_end;
      if (take_req) begin
        pend_q    <= 1'b1;
        req_ready <= 1'b0;
        busy      <= 1'b1;
      end else if (access_start) begin
        pend_q <= 1'b0;
      end else if (access_end) begin
        req_ready <= 1'b1;
        busy      <= 1'b0;
      end
    end
  end

  // ****************************************
  // Select group drive
  // ****************************************
  // R1 selects before read strobe
  // R3 selects before write strobe
  // R5 select group content
  // R2 read hold keeps selects
  // R4 write hold keeps data
  always @(posedge core_clk) begin
    if (!rstn) begin
      chip_space_select_n <= `AMSC_SEL_RST;
      byte_lane_enable_n  <= `AMSC_BE_RST;
      word_address        <= `AMSC_ADDR_RST;
      output_enable_n     <= 1'b1;
      mem_data_out        <= `AMSC_DATA_RST;
      mem_data_oe_n       <= 1'b1;
    end else if (access_start) begin
      chip_space_select_n <= space_sel_n(space_q);
      byte_lane_enable_n  <= ~be_q;
      word_address        <= addr_q;
      output_enable_n     <= write_q;
      mem_data_out        <= wdata_q;
      mem_data_oe_n       <= ~write_q;
    end else if (access_end) begin
      chip_space_select_n <= `AMSC_SEL_RST;
      byte_lane_enable_n  <= `AMSC_BE_RST;
      output_enable_n     <= 1'b1;
      mem_data_oe_n       <= 1'b1;
    end
  end

  // ****************************************
  // Strobes and read capture
  // ****************************************
  // R11 strobe pin roles
  // R12 strobes on clock rise
  always @(posedge core_clk) begin
    if (!rstn) begin
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end else if ((state_q == ST_SETUP) && (state_d == ST_STROBE)) begin
      read_strobe_n  <= write_q;
      write_strobe_n <= ~write_q;
    end else if ((state_q == ST_STROBE) && (state_d == ST_HOLD)) begin
      read_strobe_n  <= 1'b1;
      write_strobe_n <= 1'b1;
    end
  end

  // R7 capture at strobe rise
  // Data seen here lags the pins by the two synchroniser stages
  always @(posedge core_clk) begin
    if (!rstn) begin
      rsp_rdata <= `AMSC_DATA_RST;
    end else if ((state_q == ST_STROBE) && (state_d == ST_HOLD) && !write_q) begin
      rsp_rdata <= data_s;
    end
  end

endmodule // amsc_ctrl

`default_nettype wire

// [shared/amsc_regs.vh]
`ifndef AMSC_REGS_VH
`define AMSC_REGS_VH

// ****************************************
// Widths of the memory side
// ****************************************
`define AMSC_SPACES      4
`define AMSC_SPACE_W     2
`define AMSC_ADDR_W      20
`define AMSC_DATA_W      32
`define AMSC_BE_W        4

// ****************************************
// Per-space phase count fields
// ****************************************
`define AMSC_SETUP_W     4
`define AMSC_STROBE_W    6
`define AMSC_HOLD_W      3
`define AMSC_CNT_W       6

// ****************************************
// Reset values
// ****************************************
`define AMSC_CNT_RST     6'h00
`define AMSC_CNT_ONE     6'h01
`define AMSC_SEL_RST     4'hF
`define AMSC_BE_RST      4'hF
`define AMSC_ADDR_RST    20'h00000
`define AMSC_DATA_RST    32'h00000000

// ****************************************
// Timing
// ****************************************
`define AMSC_CORE_PERIOD_NS   4
`define AMSC_SYNC_STAGES      2

`endif

// [hdl/amsc_sync.v]
`timescale 1ns/1ps
`default_nettype none

module amsc_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             core_clk,
  input  wire             rstn,
  // Asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // First stage feeds only the second stage
      always @(posedge core_clk) begin
        if (!rstn) begin
          meta_q[i] <= 1'b0;
          sync_q[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

  assign sync_out = sync_q;

endmodule // amsc_sync

`default_nettype wire

// [hdl/amsc_phase_cnt.v]
`timescale 1ns/1ps
`default_nettype none
`include "amsc_regs.vh"

module amsc_phase_cnt (
  // Clock and reset
  input  wire                   core_clk,
  input  wire                   rstn,
  // Control
  input  wire                   load,
  input  wire [`AMSC_CNT_W-1:0] load_val,
  input  wire                   step,
  // Status
  output wire                   last
);

  reg [`AMSC_CNT_W-1:0] cnt_q;

  // Saturates at one so a stretched phase stays on its last period
  always @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= `AMSC_CNT_RST;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (step && (cnt_q > `AMSC_CNT_ONE)) begin
      cnt_q <= cnt_q - `AMSC_CNT_ONE;
    end
  end

  assign last = (cnt_q <= `AMSC_CNT_ONE);

endmodule // amsc_phase_cnt

`default_nettype wire

// [tb/amsc_ctrl_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************
// Memory pin checks
// ********************
module amsc_ctrl_properties (
  // Clocks and reset
  input wire logic        core_clk,
  input wire logic        rstn,
  input wire logic        mem_clock_in,
  input wire logic        mem_clock_out,
  // Answer
  input wire logic        req_ready,
  input wire logic        rsp_valid,
  input wire logic        busy,
  input wire logic [31:0] rsp_rdata,
  // Memory pins
  input wire logic [3:0]  chip_space_select_n,
  input wire logic [19:0] word_address,
  input wire logic        output_enable_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [31:0] mem_data_in,
  input wire logic [31:0] mem_data_out,
  input wire logic        mem_data_oe_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Bench memory period is exactly 8 core cycles
  a_pin_edge_align: assert property (
    $changed({chip_space_select_n, output_enable_n, read_strobe_n, write_strobe_n}) |-> $rose(mem_clock_out))
    else $error("memory pin moved off a clock rise");
  a_clock_follow: assert property (
    $changed(mem_clock_in) |-> ##3 mem_clock_out == $past(mem_clock_in, 3))
    else $error("memory clock out does not follow input");
  a_read_setup: assert property (
    $fell(read_strobe_n) |-> !$past(output_enable_n, 8) && $stable(word_address))
    else $error("read strobe without setup period");
  a_write_setup: assert property (
    $fell(write_strobe_n) |-> !$past(mem_data_oe_n, 8) && $stable(mem_data_out) && output_enable_n)
    else $error("write strobe without setup period");
  a_read_hold: assert property (
    $rose(read_strobe_n) |-> (!output_enable_n && $stable(word_address))[*8])
    else $error("read selects dropped inside hold");
  a_write_hold: assert property (
    $rose(write_strobe_n) |-> (!mem_data_oe_n && chip_space_select_n != 4'hF && $stable(mem_data_out))[*8])
    else $error("write selects dropped inside hold");
  a_strobe_width: assert property (
    $fell(read_strobe_n) |-> (!read_strobe_n)[*8])
    else $error("read strobe shorter than one period");
  a_one_space: assert property (
    !output_enable_n || !mem_data_oe_n |-> $onehot(~chip_space_select_n) && (output_enable_n ^ mem_data_oe_n))
    else $error("select group malformed");
  a_rdata_capture: assert property (
    $rose(read_strobe_n) |-> rsp_rdata == $past(mem_data_in, 3))
    else $error("read data not taken at strobe rise");
  a_answer_pulse: assert property (
    rsp_valid |-> !busy && req_ready ##1 !rsp_valid)
    else $error("answer pulse malformed");
endmodule // amsc_ctrl_properties

bind amsc_ctrl amsc_ctrl_properties chk_u (.core_clk, .rstn, .mem_clock_in, .mem_clock_out, .req_ready,
  .rsp_valid, .busy, .rsp_rdata, .chip_space_select_n, .word_address, .output_enable_n, .read_strobe_n,
  .write_strobe_n, .mem_data_in, .mem_data_out, .mem_data_oe_n);
`default_nettype wire

// [tb/amsc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ********************
// Asynchronous memory
// ********************
module amsc_mem_model (
  // Memory pins
  input  wire logic        mem_clock_out,
  input  wire logic [3:0]  chip_space_select_n,
  input  wire logic [3:0]  byte_lane_enable_n,
  input  wire logic [19:0] word_address,
  input  wire logic        output_enable_n,
  input  wire logic        read_strobe_n,
  input  wire logic        write_strobe_n,
  input  wire logic [31:0] mem_data_out,
  output logic [31:0]      mem_data_in,
  output logic             async_ready,
  // Stall length in units of two memory clock periods
  input  wire logic [3:0]  stall_periods
);
  logic [31:0] mem [0:1023];
  logic [31:0] last;
  wire  [9:0]  key = {chip_space_select_n, word_address[5:0]};
  wire         rd  = !output_enable_n && chip_space_select_n != 4'hF;
  initial begin
    async_ready = 1'b1;
    last = 32'h00000000;
    for (int i = 0; i < 1024; i++) mem[i] = 32'h00000000;
  end
  always @* if (rd) last = mem[key];
  // Released bus shows the inverse, never the last word
  assign mem_data_in = rd ? mem[key] : ~last;
  always @(posedge write_strobe_n) if (chip_space_select_n != 4'hF)
    for (int b = 0; b < 4; b++) if (!byte_lane_enable_n[b]) mem[key][8*b +: 8] = mem_data_out[8*b +: 8];
  // ready level held 2E per stall
  always @(negedge (read_strobe_n & write_strobe_n)) if (stall_periods != 4'h0) begin
    @(negedge mem_clock_out);
    async_ready = 1'b0;
    repeat (2 * stall_periods) @(negedge mem_clock_out);
    async_ready = 1'b1;
  end
endmodule // amsc_mem_model
`default_nettype wire

// [tb/amsc_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module amsc_ctrl_tb;
  // ********************
  // Stimulus and pins
  // ********************
  logic        core_clk, rstn, mem_clock_in, req_valid, req_write, mco_q;
  logic [1:0]  req_space;
  logic [3:0]  req_byte_en, stall_periods;
  logic [19:0] req_addr;
  logic [31:0] req_wdata;
  logic [15:0] cfg_read_setup_cycles, cfg_write_setup_cycles;
  logic [23:0] cfg_read_strobe_cycles, cfg_write_strobe_cycles;
  logic [11:0] cfg_read_hold_cycles, cfg_write_hold_cycles;
  wire logic        mem_clock_out, req_ready, rsp_valid, busy, output_enable_n;
  wire logic        read_strobe_n, write_strobe_n, mem_data_oe_n, async_ready;
  wire logic [3:0]  chip_space_select_n, byte_lane_enable_n;
  wire logic [19:0] word_address;
  wire logic [31:0] rsp_rdata, mem_data_in, mem_data_out;
  int mismatches = 0;
  int n_tests = 0;
  int su, st, ho, seen;

  amsc_ctrl dut_u (.*);
  amsc_mem_model mem_u (.*);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Link clock free running, phase unrelated to core
  initial begin
    mem_clock_in = 1'b0;
    #1.3;
    forever #16 mem_clock_in = ~mem_clock_in;
  end
  // Periods per phase, counted at memory clock rises
  always @(posedge core_clk) begin
    if (mem_clock_out && !mco_q) begin
      if (!read_strobe_n || !write_strobe_n) begin
        st++;
        seen = 1;
      end else if (chip_space_select_n != 4'hF) begin
        if (seen) ho++;
        else su++;
      end
    end
    mco_q <= mem_clock_out;
  end

  function automatic int e(input int v);
    return (v == 0) ? 1 : v;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic acc(input logic w, input int sp, input logic [19:0] a, input logic [3:0] be,
                     input logic [31:0] d, input int rs, input int rst, input int rh);
    int n;
    int k;
    @(posedge core_clk);
    k = 2 * stall_periods + 1;
    req_valid <= 1'b1;
    req_write <= w;
    req_space <= sp[1:0];
    req_addr <= a;
    req_byte_en <= be;
    req_wdata <= d;
    su = 0;
    st = 0;
    ho = 0;
    seen = 0;
    @(posedge core_clk);
    chk(req_ready, 1'b1, "ready at take");
    req_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk({busy, req_ready}, 2'b10, "busy during access");
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk(n < 1000, 1'b1, "answer in time");
    chk(su, e(rs), "setup periods");
    chk(st, (stall_periods != 0 && k > e(rst)) ? k : e(rst), "strobe periods");
    chk(ho, e(rh), "hold periods");
  endtask

  task automatic rd(input int s, input logic [19:0] a, input logic [31:0] exp);
    acc(1'b0, s, a, 4'hF, 32'h0, cfg_read_setup_cycles[4*s +: 4], cfg_read_strobe_cycles[6*s +: 6],
        cfg_read_hold_cycles[3*s +: 3]);
    chk(rsp_rdata, exp, "read data");
  endtask

  task automatic wr(input int s, input logic [19:0] a, input logic [3:0] be, input logic [31:0] d);
    acc(1'b1, s, a, be, d, cfg_write_setup_cycles[4*s +: 4], cfg_write_strobe_cycles[6*s +: 6],
        cfg_write_hold_cycles[3*s +: 3]);
  endtask

  task give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_space = 2'h0;
    req_addr = 20'h00000;
    req_byte_en = 4'h0;
    req_wdata = 32'h00000000;
    stall_periods = 4'h0;
    // Zero fields included: they count as one period
    cfg_read_setup_cycles = 16'h3210;
    cfg_read_strobe_cycles = {6'h04, 6'h03, 6'h02, 6'h01};
    cfg_read_hold_cycles = {3'h1, 3'h2, 3'h3, 3'h0};
    cfg_write_setup_cycles = 16'h3201;
    cfg_write_strobe_cycles = {6'h03, 6'h00, 6'h01, 6'h02};
    cfg_write_hold_cycles = {3'h3, 3'h1, 3'h0, 3'h2};
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    chk({chip_space_select_n, read_strobe_n, write_strobe_n, output_enable_n, mem_data_oe_n, req_ready, busy},
        10'h3FE, "reset pin levels");
    $display("reset test done");
    for (int s = 0; s < 4; s++) begin
      wr(s, 20'(5 * s + 1), 4'hF, 32'hC0DE0000 + s);
      rd(s, 20'(5 * s + 1), 32'hC0DE0000 + s);
    end
    $display("space test done");
    wr(2, 20'h00003, 4'hF, 32'hFFFFFFFF);
    wr(2, 20'h00003, 4'h5, 32'h12345678);
    rd(2, 20'h00003, 32'hFF34FF78);
    $display("byte lane test done");
    stall_periods <= 4'h1;
    rd(0, 20'h00001, 32'hC0DE0000);
    stall_periods <= 4'h2;
    wr(3, 20'h00010, 4'hF, 32'h0BADF00D);
    stall_periods <= 4'h0;
    rd(3, 20'h00010, 32'h0BADF00D);
    $display("ready stall test done");
    cfg_read_setup_cycles[3:0] <= 4'hF;
    cfg_read_strobe_cycles[5:0] <= 6'h3F;
    cfg_read_hold_cycles[2:0] <= 3'h7;
    @(posedge core_clk);
    rd(0, 20'h00001, 32'hC0DE0000);
    $display("longest count test done");
    give_verdict;
  end

  initial begin
    #100000;
    mismatches++;
    give_verdict;
  end
endmodule // amsc_ctrl_tb
`default_nettype wire
